// ===== verilog/ext_irq_defs.vh
// register map, field positions and reset values of the external interrupt block
`ifndef EXT_IRQ_DEFS_VH
`define EXT_IRQ_DEFS_VH

// ==========================================================================
// register byte addresses
`define ADDR_PRIORITY_BANK_0   8'h24
`define ADDR_PRIORITY_BANK_1   8'h25
`define ADDR_PRIORITY_BANK_2   8'h26
`define ADDR_PRIORITY_BANK_3   8'h27
`define ADDR_EXT_SENSE_CONTROL 8'h28
`define ADDR_IRQ_STATUS        8'h29
`define ADDR_IRQ_MASK          8'h2A

// ==========================================================================
// ext_sense_control fields
`define SEL_PORTB_HI   7
`define SEL_PORTB_LO   6
`define INVERT_PORTB   5
`define SEL_PORTAF_HI  4
`define SEL_PORTAF_LO  3
`define INVERT_PORTA   2

// ==========================================================================
// reset values and constant fields
`define SENSE_RESET    8'h00
`define PRIORITY_RESET 8'hFF
`define BANK3_RO_MASK  8'hF0
`define PAIR_LEVEL0    2'h2
`define STATUS_BITS    4
`define MASK_RESET     4'h0

// ==========================================================================
// sensitivity selector codes
`define SENSE_LEVEL    2'h0
`define SENSE_EDGE_A   2'h1
`define SENSE_EDGE_B   2'h2
`define SENSE_BOTH     2'h3

`endif

// ===== verilog/ext_irq_detect.v
// one external interrupt group: pin detection, OR and request latch
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defs.vh"

module ext_irq_detect #(
  parameter WIDTH = 4
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pins,
  input  wire [WIDTH-1:0] pin_enable,
  input  wire [1:0]       sense_sel,
  input  wire             invert,
  input  wire             config_changed,
  input  wire             vector_fetch,
  output reg              request,
  output reg              event_pulse
);

  // ==========================================================================
  // edge and level detection
  reg  [WIDTH-1:0] pins_prev;
  wire [WIDTH-1:0] pins_eff;
  wire [WIDTH-1:0] fall_raw;
  wire [WIDTH-1:0] rise_raw;
  wire [WIDTH-1:0] fall;
  wire [WIDTH-1:0] rise;
  reg  [WIDTH-1:0] hit;
  wire             any_hit;

  // edges taken on raw pins: flipping invert over a steady pin
  // must not look like an edge
  assign pins_eff = invert ? ~pins : pins;
  assign fall_raw = pins_prev & ~pins & pin_enable;
  assign rise_raw = ~pins_prev & pins & pin_enable;
  // inversion maps every mode onto its mirror image
  assign fall     = invert ? rise_raw : fall_raw;
  assign rise     = invert ? fall_raw : rise_raw;

  always @*
  begin
    case (sense_sel)
      `SENSE_LEVEL:  hit = fall | (~pins_eff & pin_enable);
      `SENSE_EDGE_A: hit = rise;
      `SENSE_EDGE_B: hit = fall;
      `SENSE_BOTH:   hit = rise | fall;
      default:       hit = {WIDTH{1'b0}};
    endcase
  end

  assign any_hit = |hit;

  // ==========================================================================
  // request latch
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_prev   <= {WIDTH{1'b1}};
      request     <= 1'b0;
      event_pulse <= 1'b0;
    end
    else
    begin
      pins_prev   <= pins;
      event_pulse <= any_hit & ~request;
      // a new hit wins over a fetch in the same cycle
      if (config_changed)
        request <= 1'b0;
      else if (any_hit)
        request <= 1'b1;
      else if (vector_fetch)
        request <= 1'b0;
    end
  end

endmodule // ext_irq_detect
`default_nettype wire

// ===== verilog/ext_irq_sense.v
// external interrupt sensitivity control with priority registers, wishbone
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defs.vh"

module ext_irq_sense #(
  parameter PA_W = 4,
  parameter PF_W = 3,
  parameter PB_W = 4
) (
  input  wire            sys_clk,
  input  wire            rst_n,
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  input  wire            wb_we_i,
  input  wire [7:0]      wb_adr_i,
  input  wire [7:0]      wb_dat_i,
  input  wire            wb_sel_i,
  output reg  [7:0]      wb_dat_o,
  output reg             wb_ack_o,
  input  wire            mask_hi,
  input  wire            mask_lo,
  input  wire [PA_W-1:0] porta_pins,
  input  wire [PA_W-1:0] porta_irq_en,
  input  wire [PF_W-1:0] portf_pins,
  input  wire [PF_W-1:0] portf_irq_en,
  input  wire [PB_W-1:0] portb_low_pins,
  input  wire [PB_W-1:0] portb_low_irq_en,
  input  wire            portb_hi_pin,
  input  wire            portb_hi_irq_en,
  input  wire [3:0]      vector_fetch,
  output reg             ext_irq_porta,
  output reg             ext_irq_portf,
  output reg             ext_irq_portb_low,
  output reg             ext_irq_portb_hi,
  output reg  [31:0]     priority_levels,
  output reg             irq
);

  // ==========================================================================
  // decode helpers
  function [7:0] merge_pairs;
    input [7:0] old_val;
    input [7:0] new_val;
    integer k;
    begin
      merge_pairs = old_val;
      for (k = 0; k < 4; k = k + 1)
        if (new_val[2*k +: 2] != `PAIR_LEVEL0)
          merge_pairs[2*k +: 2] = new_val[2*k +: 2];
    end
  endfunction

  // ==========================================================================
  // registers and bus strobes
  reg  [7:0] priority_bank [0:3];
  reg  [7:0] ext_sense_control;
  reg  [3:0] irq_status;
  reg  [3:0] irq_mask;
  reg  [7:0] next_dat;
  wire       bus_req;
  wire       wr_en;
  wire       level3;
  wire       sense_wr;
  wire [7:0] next_sense;
  wire       chg_b;
  wire       chg_af;
  wire [3:0] req_w;
  wire [3:0] evt_w;
  integer    i;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en    = bus_req & wb_we_i & wb_sel_i;
  assign level3   = mask_hi & mask_lo;
  assign sense_wr = wr_en & (wb_adr_i == `ADDR_EXT_SENSE_CONTROL) & level3;
  // reserved bits forced to zero whatever software writes
  assign next_sense = {wb_dat_i[7:2], 2'b00};

  assign chg_b  = sense_wr &
                  ((next_sense[7:6] != ext_sense_control[7:6]) ||
                   (next_sense[5] != ext_sense_control[5]));
  assign chg_af = sense_wr &
                  ((next_sense[4:3] != ext_sense_control[4:3]) ||
                   (next_sense[2] != ext_sense_control[2]));

  // ==========================================================================
  // wishbone slave: one registered ack per request, one cycle after it
  always @*
  begin
    case (wb_adr_i)
      `ADDR_PRIORITY_BANK_0:   next_dat = priority_bank[0];
      `ADDR_PRIORITY_BANK_1:   next_dat = priority_bank[1];
      `ADDR_PRIORITY_BANK_2:   next_dat = priority_bank[2];
      `ADDR_PRIORITY_BANK_3:   next_dat = priority_bank[3] | `BANK3_RO_MASK;
      `ADDR_EXT_SENSE_CONTROL: next_dat = ext_sense_control;
      `ADDR_IRQ_STATUS:        next_dat = {4'h0, irq_status};
      `ADDR_IRQ_MASK:          next_dat = {4'h0, irq_mask};
      default:                 next_dat = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_dat : 8'h00;
    end
  end

  // ==========================================================================
  // register writes
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 4; i = i + 1)
        priority_bank[i] <= `PRIORITY_RESET;
      ext_sense_control <= `SENSE_RESET;
      irq_mask          <= `MASK_RESET;
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
        if (wr_en && wb_adr_i == (`ADDR_PRIORITY_BANK_0 + i[7:0]))
          priority_bank[i] <= merge_pairs(priority_bank[i], wb_dat_i);
      priority_bank[3][7:4] <= 4'hF;
      // ignored below level 3 so a live group never sees a half change
      if (sense_wr)
        ext_sense_control <= next_sense;
      if (wr_en && wb_adr_i == `ADDR_IRQ_MASK)
        irq_mask <= wb_dat_i[3:0];
    end
  end

  // ==========================================================================
  // group detectors
  ext_irq_detect #(.WIDTH(PA_W)) u_porta (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .pins           (porta_pins),
    .pin_enable     (porta_irq_en),
    .sense_sel      (ext_sense_control[`SEL_PORTAF_HI:`SEL_PORTAF_LO]),
    .invert         (ext_sense_control[`INVERT_PORTA]),
    .config_changed (chg_af),
    .vector_fetch   (vector_fetch[0]),
    .request        (req_w[0]),
    .event_pulse    (evt_w[0])
  );

  ext_irq_detect #(.WIDTH(PF_W)) u_portf (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .pins           (portf_pins),
    .pin_enable     (portf_irq_en),
    .sense_sel      (ext_sense_control[`SEL_PORTAF_HI:`SEL_PORTAF_LO]),
    .invert         (1'b0),
    .config_changed (chg_af),
    .vector_fetch   (vector_fetch[1]),
    .request        (req_w[1]),
    .event_pulse    (evt_w[1])
  );

  ext_irq_detect #(.WIDTH(PB_W)) u_portb_low (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .pins           (portb_low_pins),
    .pin_enable     (portb_low_irq_en),
    .sense_sel      (ext_sense_control[`SEL_PORTB_HI:`SEL_PORTB_LO]),
    .invert         (ext_sense_control[`INVERT_PORTB]),
    .config_changed (chg_b),
    .vector_fetch   (vector_fetch[2]),
    .request        (req_w[2]),
    .event_pulse    (evt_w[2])
  );

  ext_irq_detect #(.WIDTH(1)) u_portb_hi (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .pins           (portb_hi_pin),
    .pin_enable     (portb_hi_irq_en),
    .sense_sel      (ext_sense_control[`SEL_PORTB_HI:`SEL_PORTB_LO]),
    .invert         (1'b0),
    .config_changed (chg_b),
    .vector_fetch   (vector_fetch[3]),
    .request        (req_w[3]),
    .event_pulse    (evt_w[3])
  );

  // ==========================================================================
  // outputs, sticky status and summary interrupt
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_irq_porta     <= 1'b0;
      ext_irq_portf     <= 1'b0;
      ext_irq_portb_low <= 1'b0;
      ext_irq_portb_hi  <= 1'b0;
      priority_levels   <= 32'hFFFFFFFF;
      irq_status        <= 4'h0;
      irq               <= 1'b0;
    end
    else
    begin
      ext_irq_porta     <= req_w[0];
      ext_irq_portf     <= req_w[1];
      ext_irq_portb_low <= req_w[2];
      ext_irq_portb_hi  <= req_w[3];
      priority_levels   <= {priority_bank[3], priority_bank[2],
                            priority_bank[1], priority_bank[0]};
      // a new event wins over a write-one clear in the same cycle
      if (wr_en && wb_adr_i == `ADDR_IRQ_STATUS)
        irq_status <= (irq_status & ~wb_dat_i[3:0]) | evt_w;
      else
        irq_status <= irq_status | evt_w;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule // ext_irq_sense
`default_nettype wire

// ===== verif/ext_irq_core_model.sv
// core side model: interrupt mask level and vector fetch
`timescale 1ns/100ps
`default_nettype none
module ext_irq_core_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] request,
  output var  logic       mask_hi,
  output var  logic       mask_lo,
  output var  logic [3:0] vector_fetch
);
  // ========
  // core behaviour
  initial
  begin
    {mask_hi, mask_lo} = 2'h3;
    vector_fetch = 4'h0;
  end
  task automatic set_level(input logic [1:0] l);
    {mask_hi, mask_lo} <= l;
  endtask
  // a core only fetches vectors whose request stands
  task automatic fetch(input logic [3:0] s);
    begin
      vector_fetch <= s & request;
      @(posedge sys_clk);
      vector_fetch <= 4'h0;
    end
  endtask
endmodule // ext_irq_core_model
`default_nettype wire

// ===== verif/ext_irq_sense_properties.sv
// port checker of the external interrupt sensitivity block
`timescale 1ns/100ps
`default_nettype none
module ext_irq_sense_checker #(
  parameter PA_W = 4
) (
  input wire logic            sys_clk,
  input wire logic            rst_n,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [7:0]      wb_dat_i,
  input wire logic            wb_sel_i,
  input wire logic [7:0]      wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [PA_W-1:0] porta_irq_en,
  input wire logic            ext_irq_porta,
  input wire logic [31:0]     priority_levels
);
  // ========
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_ack_after_take:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after a request");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_needs_req:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_idle_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
    else $error("read data outside ack");
  a_bank3_read_ones:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h27
      |-> wb_dat_o[7:4] == 4'hF) else $error("bank 3 upper bits not ones");
  a_bank3_level_ones:
    assert property (priority_levels[31:28] == 4'hF)
    else $error("bank 3 upper levels not ones");
  a_prio_after_reset:
    assert property ($rose(rst_n) |-> priority_levels == 32'hFFFFFFFF)
    else $error("priority not ones after reset");
  a_level0_write_kept:
    assert property (wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == 8'h24
      && wb_dat_i[5:4] == 2'h2 |=> $stable(priority_levels[5:4]))
    else $error("pair value 10 was stored");
  a_pair_write_taken:
    assert property (wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == 8'h24
      && wb_dat_i[1:0] != 2'h2 |=> priority_levels[1:0] == $past(wb_dat_i[1:0]))
    else $error("priority pair not written");
  a_req_needs_enable:
    assert property ($rose(ext_irq_porta) |-> $past(porta_irq_en != 0)
      || $past(porta_irq_en != 0, 2) || $past(porta_irq_en != 0, 3))
    else $error("request from disabled pins");
endmodule // ext_irq_sense_checker
bind ext_irq_sense ext_irq_sense_checker #(.PA_W(PA_W)) u_checker (.*);
`default_nettype wire

// ===== verif/ext_irq_sense_test.sv
// self-checking bench of the external interrupt sensitivity block
`timescale 1ns/100ps
`default_nettype none
module ext_irq_sense_test;
  logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i;
  logic [7:0]  wb_adr_i, wb_dat_i, wb_dat_o, cfg;
  logic        wb_ack_o, mask_hi, mask_lo, portb_hi_pin, portb_hi_irq_en;
  logic [3:0]  porta_pins, porta_irq_en, portb_low_pins, portb_low_irq_en;
  logic [2:0]  portf_pins, portf_irq_en;
  logic [3:0]  vector_fetch, reqs;
  logic        ext_irq_porta, ext_irq_portf, ext_irq_portb_low;
  logic        ext_irq_portb_hi, irq;
  logic [31:0] priority_levels;
  int          n_errors = 0;
  int          checks_done = 0;
  assign reqs = {ext_irq_portb_hi, ext_irq_portb_low, ext_irq_portf,
                 ext_irq_porta};
  ext_irq_sense u_dut (.*);
  ext_irq_core_model u_core (.sys_clk, .request(reqs), .mask_hi, .mask_lo,
                             .vector_fetch);
  always #5 sys_clk = ~sys_clk;
  // ========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    begin
      checks_done++;
      if (g !== e)
      begin
        n_errors++;
        $display("unexpected %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task automatic wb(input logic w, input logic s, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    begin
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, s};
      {wb_adr_i, wb_dat_i} <= {a, d};
      do
        @(posedge sys_clk);
      while (wb_ack_o !== 1'b1 && ++n < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (n >= 20)
        n_errors++;
      @(posedge sys_clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    begin
      wb(1'b0, 1'b1, a, 8'h00, q);
      chk($sformatf("register %0h", a), {24'h0, e}, {24'h0, q});
    end
  endtask
  task automatic pins(input logic v);
    {porta_pins, portf_pins, portb_low_pins, portb_hi_pin} <= {12{v}};
  endtask
  // edge modes only: level modes would re-raise across the fetch
  task automatic step(input logic v, input logic [3:0] e);
    begin
      pins(v);
      repeat (4) @(posedge sys_clk);
      chk("requests", {28'h0, e}, {28'h0, reqs});
      u_core.fetch(4'hF);
      repeat (3) @(posedge sys_clk);
    end
  endtask
  function automatic logic [3:0] hit(input logic [1:0] s, input logic i,
                                     input logic f);
    logic inv, pl;
    begin
      inv = s == 2'h3 || (s == 2'h2 && (f ^ i)) || (s == 2'h1 && !(f ^ i));
      pl = s == 2'h3 || (s == 2'h2 && f) || (s == 2'h1 && !f);
      hit = {pl, inv, pl, inv};
    end
  endfunction
  task automatic wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ========
  // tests
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 6'h0;
    {wb_adr_i, wb_dat_i} = 16'h0;
    {porta_pins, portf_pins, portb_low_pins, portb_hi_pin} = 12'hFFF;
    {porta_irq_en, portf_irq_en, portb_low_irq_en, portb_hi_irq_en} = 12'hFFF;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int a = 8'h24; a < 8'h28; a++)
      rd(a[7:0], 8'hFF);
    rd(8'h28, 8'h00);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    wr(8'h24, 8'hCF);
    wr(8'h24, 8'h64);
    wr(8'h27, 8'h00);
    wb(1'b1, 1'b0, 8'h25, 8'h00, cfg);
    rd(8'h24, 8'h44);
    rd(8'h27, 8'hF0);
    rd(8'h25, 8'hFF);
    chk("priority_levels", 32'hF0FFFF44, priority_levels);
    $display("test priority done");
    for (int s = 1; s < 4; s++)
      for (int i = 0; i < 2; i++)
      begin
        cfg = {s[1:0], i[0], s[1:0], i[0], 2'b00};
        wr(8'h28, cfg);
        rd(8'h28, cfg);
        step(1'b0, hit(s[1:0], i[0], 1'b1));
        step(1'b1, hit(s[1:0], i[0], 1'b0));
      end
    $display("test edge modes done");
    pins(1'b0);
    repeat (4) @(posedge sys_clk);
    chk("requests", 32'hF, {28'h0, reqs});
    wr(8'h28, 8'hD8);
    repeat (2) @(posedge sys_clk);
    chk("requests", 32'h0, {28'h0, reqs});
    u_core.set_level(2'h2);
    wr(8'h28, 8'h24);
    rd(8'h28, 8'hD8);
    u_core.set_level(2'h3);
    $display("test clear and gating done");
    wr(8'h29, 8'h0F);
    wr(8'h28, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk("requests", 32'hF, {28'h0, reqs});
    u_core.fetch(4'hF);
    repeat (4) @(posedge sys_clk);
    chk("requests", 32'hF, {28'h0, reqs});
    pins(1'b1);
    repeat (3) @(posedge sys_clk);
    u_core.fetch(4'hF);
    repeat (4) @(posedge sys_clk);
    chk("requests", 32'h0, {28'h0, reqs});
    $display("test level mode done");
    rd(8'h29, 8'h0F);
    wr(8'h2A, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h29, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h29, 8'h0B);
    $display("test interrupt done");
    porta_irq_en <= 4'h0;
    pins(1'b0);
    repeat (4) @(posedge sys_clk);
    chk("requests", 32'hE, {28'h0, reqs});
    wr(8'h28, 8'h24);
    repeat (3) @(posedge sys_clk);
    chk("requests", 32'hA, {28'h0, reqs});
    $display("test enable and inverted level done");
    wrap_up();
  end
endmodule // ext_irq_sense_test
`default_nettype wire
